// ---- hw/timer_counter_pwm_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module timer_counter_pwm_unit
    import tcu_pkg::*;
#(
    parameter int N_CH = NUM_CH,
    parameter int CW = CNT_W
)(
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [DATA_W-1:0] I_PWDATA,
    input wire logic [N_CH-1:0] I_CAPTURE,
    input wire logic [N_CH-1:0] I_KILL,
    output logic [DATA_W-1:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [N_CH-1:0] O_PWM,
    output logic [N_CH-1:0] O_PWM_N,
    output logic O_IRQ
);
    // software-visible configuration, one set per channel
    logic [CTRL_W-1:0] ctrl_q [N_CH];
    logic [CTRL_W-1:0] ctrl_d [N_CH];
    logic [CW-1:0] period_q [N_CH];
    logic [CW-1:0] period_d [N_CH];
    logic [CW-1:0] compare_q [N_CH];
    logic [CW-1:0] compare_d [N_CH];
    logic [DEAD_W-1:0] dead_q [N_CH];
    logic [DEAD_W-1:0] dead_d [N_CH];

    // global registers
    logic [INT_W-1:0] status_q, status_d;
    logic [INT_W-1:0] mask_q, mask_d;
    logic [PRE_W-1:0] prescale_q, prescale_d;
    logic [PRE_W-1:0] pre_cnt_q, pre_cnt_d;
    logic irq_q, irq_d;

    // bus answer registers
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;

    // channel results
    logic [CW-1:0] count_w [N_CH];
    logic [CW-1:0] capture_w [N_CH];
    logic [N_CH-1:0] match_w;
    logic [N_CH-1:0] cap_evt_w;
    logic [N_CH-1:0] raw_w;
    logic [N_CH-1:0] running_w;
    logic [N_CH-1:0] pwm_w;
    logic [N_CH-1:0] pwm_n_w;

    // decoded bus strobes
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic rd_done;
    logic chan_hit;
    logic [CH_W-1:0] ch_sel;
    logic [2:0] reg_sel;
    logic tick;
    logic [INT_W-1:0] events;
    logic [INT_W-1:0] clr_bits;

    // apb phases; ready is only high in the access cycle
    assign setup_ph = I_PSEL && !I_PENABLE;
    assign access_ph = I_PSEL && I_PENABLE && ready_q;
    assign wr_en = access_ph && I_PWRITE && !err_q;
    assign rd_done = access_ph && !I_PWRITE;
    assign chan_hit = is_chan(I_PADDR);
    assign ch_sel = chan_of(I_PADDR);
    assign reg_sel = reg_of(I_PADDR);

    // shared prescaler: one-cycle enable every prescale+1 clocks
    // compare is >= so lowering the prescale never stalls ticks for a wrap
    always_comb begin
        tick = (pre_cnt_q >= prescale_q);
        pre_cnt_d = tick ? '0 : pre_cnt_q + 1'b1;
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_d;
        end
    end

    // register writes; count and capture are read-only
    always_comb begin
        ctrl_d = ctrl_q;
        period_d = period_q;
        compare_d = compare_q;
        dead_d = dead_q;
        mask_d = mask_q;
        prescale_d = prescale_q;
        if (wr_en && chan_hit) begin
            case (reg_sel)
                REG_CTRL: begin
                    ctrl_d[ch_sel] = I_PWDATA[CTRL_W-1:0];
                end
                REG_PERIOD: begin
                    period_d[ch_sel] = I_PWDATA[CW-1:0];
                end
                REG_COMPARE: begin
                    compare_d[ch_sel] = I_PWDATA[CW-1:0];
                end
                REG_DEAD: begin
                    dead_d[ch_sel] = I_PWDATA[DEAD_W-1:0];
                end
                default: begin
                end
            endcase
        end else if (wr_en) begin
            case (I_PADDR)
                ADDR_INT_MASK: begin
                    mask_d = I_PWDATA[INT_W-1:0];
                end
                ADDR_PRESCALE: begin
                    prescale_d = I_PWDATA[PRE_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            for (int i = 0; i < N_CH; i++) begin
                ctrl_q[i] <= CTRL_RST;
                period_q[i] <= PERIOD_RST;
                compare_q[i] <= COMPARE_RST;
                dead_q[i] <= DEAD_RST;
            end
            mask_q <= INT_RST;
            prescale_q <= PRESCALE_RST;
        end else begin
            ctrl_q <= ctrl_d;
            period_q <= period_d;
            compare_q <= compare_d;
            dead_q <= dead_d;
            mask_q <= mask_d;
            prescale_q <= prescale_d;
        end
    end

    // read data is prepared in the setup cycle so it leaves a flop
    always_comb begin
        rdata_d = rdata_q;
        err_d = 1'b0;
        ready_d = setup_ph;
        if (setup_ph) begin
            rdata_d = '0;
            if (chan_hit) begin
                case (reg_sel)
                    REG_CTRL: begin
                        rdata_d[CTRL_W-1:0] = ctrl_q[ch_sel];
                        rdata_d[CTRL_RUN_BIT] = running_w[ch_sel];
                    end
                    REG_PERIOD: begin
                        rdata_d[CW-1:0] = period_q[ch_sel];
                    end
                    REG_COMPARE: begin
                        rdata_d[CW-1:0] = compare_q[ch_sel];
                    end
                    REG_DEAD: begin
                        rdata_d[DEAD_W-1:0] = dead_q[ch_sel];
                    end
                    REG_COUNT: begin
                        rdata_d[CW-1:0] = count_w[ch_sel];
                    end
                    default: begin
                        rdata_d[CW-1:0] = capture_w[ch_sel];
                    end
                endcase
            end else begin
                case (I_PADDR)
                    ADDR_INT_STATUS: begin
                        rdata_d[INT_W-1:0] = status_q;
                    end
                    ADDR_INT_MASK: begin
                        rdata_d[INT_W-1:0] = mask_q;
                    end
                    ADDR_PRESCALE: begin
                        rdata_d[PRE_W-1:0] = prescale_q;
                    end
                    default: begin
                        // unmapped: error answer, zero data
                        err_d = 1'b1;
                    end
                endcase
            end
        end else if (access_ph) begin
            err_d = 1'b0;
        end else begin
            err_d = err_q;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    // sticky events; only bits the read returned are cleared,
    // so an event landing on the clearing edge survives
    always_comb begin
        events = {cap_evt_w, match_w};
        clr_bits = '0;
        if (rd_done && !err_q && I_PADDR == ADDR_INT_STATUS) begin
            clr_bits = rdata_q[INT_W-1:0];
        end
        status_d = (status_q & ~clr_bits) | events;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            status_q <= INT_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    // independent channels, each with its own dead-band stage
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        counter_channel #(
            .W(CW)
        ) u_cnt (
            .i_clk(I_CLK_SYS),
            .i_reset(I_RESET),
            .i_tick(tick),
            .i_enable(ctrl_q[g][CTRL_EN_BIT]),
            .i_oneshot(ctrl_q[g][CTRL_ONESHOT_BIT]),
            .i_period(period_q[g]),
            .i_compare(compare_q[g]),
            .i_capture(I_CAPTURE[g]),
            .o_count(count_w[g]),
            .o_capture(capture_w[g]),
            .o_match(match_w[g]),
            .o_cap_evt(cap_evt_w[g]),
            .o_pwm_raw(raw_w[g]),
            .o_running(running_w[g])
        );

        // kill bypasses software entirely, acts on the next edge
        dead_band_pair #(
            .W(DEAD_W)
        ) u_db (
            .i_clk(I_CLK_SYS),
            .i_reset(I_RESET),
            .i_raw(raw_w[g]),
            .i_dead(dead_q[g]),
            .i_kill(I_KILL[g]),
            .o_true(pwm_w[g]),
            .o_compl(pwm_n_w[g])
        );
    end

    // all outputs are flop outputs
    assign O_PRDATA = rdata_q;
    assign O_PREADY = ready_q;
    assign O_PSLVERR = err_q;
    assign O_PWM = pwm_w;
    assign O_PWM_N = pwm_n_w;
    assign O_IRQ = irq_q;
endmodule
`default_nettype wire

// ---- hw/tcu_pkg.sv ----
`default_nettype none
package tcu_pkg;
    // channel count and widths
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int CNT_W = 16;
    localparam int DEAD_W = 8;
    localparam int PRE_W = 8;
    localparam int CTRL_W = 2;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int INT_W = 2 * NUM_CH;

    // channel window: addr[7:5] picks channel, addr[4:2] the register
    localparam logic [3:0] CHAN_PAGE = 4'h0;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_PERIOD = 3'h1;
    localparam logic [2:0] REG_COMPARE = 3'h2;
    localparam logic [2:0] REG_DEAD = 3'h3;
    localparam logic [2:0] REG_COUNT = 3'h4;
    localparam logic [2:0] REG_CAPTURE = 3'h5;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h100;
    localparam logic [11:0] ADDR_INT_MASK = 12'h104;
    localparam logic [11:0] ADDR_PRESCALE = 12'h108;

    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ONESHOT_BIT = 1;
    localparam int CTRL_RUN_BIT = 8;
    localparam int INT_CAP_BASE = NUM_CH;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
    localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
    localparam logic [PRE_W-1:0] PRESCALE_RST = 8'h00;
    localparam logic [INT_W-1:0] INT_RST = 16'h0000;

    typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_HALT} ch_state_t;

    // address decode helpers, used by read and write paths
    function automatic logic is_chan(input logic [ADDR_W-1:0] a);
        return (a[11:8] == CHAN_PAGE) && (a[4:2] <= REG_CAPTURE);
    endfunction

    function automatic logic [CH_W-1:0] chan_of(input logic [ADDR_W-1:0] a);
        return a[7:5];
    endfunction

    function automatic logic [2:0] reg_of(input logic [ADDR_W-1:0] a);
        return a[4:2];
    endfunction
endpackage
`default_nettype wire

// ---- hw/counter_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
module counter_channel
    import tcu_pkg::*;
#(
    parameter int W = CNT_W
)(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_enable,
    input wire logic i_oneshot,
    input wire logic [W-1:0] i_period,
    input wire logic [W-1:0] i_compare,
    input wire logic i_capture,
    output logic [W-1:0] o_count,
    output logic [W-1:0] o_capture,
    output logic o_match,
    output logic o_cap_evt,
    output logic o_pwm_raw,
    output logic o_running
);
    ch_state_t state_q, state_d;
    logic [W-1:0] count_q, count_d;
    logic [W-1:0] cap_q, cap_d;
    logic cap_prev_q;
    logic match;
    logic cap_rise;

    // count and period match on the tick cycle; capture edge checked every clock
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        match = 1'b0;
        case (state_q)
            CH_IDLE: begin
                count_d = '0;
                if (i_enable) begin
                    state_d = CH_RUN;
                end
            end
            CH_RUN: begin
                if (!i_enable) begin
                    state_d = CH_IDLE;
                end else if (i_tick) begin
                    if (count_q == i_period) begin
                        match = 1'b1;
                        if (i_oneshot) begin
                            state_d = CH_HALT;
                        end else begin
                            count_d = '0;
                        end
                    end else begin
                        count_d = count_q + 1'b1;
                    end
                end
            end
            CH_HALT: begin
                // stays frozen on the period value until disabled
                if (!i_enable) begin
                    state_d = CH_IDLE;
                end
            end
            default: begin
                state_d = CH_IDLE;
            end
        endcase
        cap_rise = i_capture && !cap_prev_q;
        cap_d = cap_rise ? count_q : cap_q;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= CH_IDLE;
            count_q <= '0;
            cap_q <= '0;
            cap_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            cap_q <= cap_d;
            cap_prev_q <= i_capture;
        end
    end

    assign o_count = count_q;
    assign o_capture = cap_q;
    assign o_match = match;
    assign o_cap_evt = cap_rise;
    assign o_running = (state_q == CH_RUN);
    assign o_pwm_raw = (state_q != CH_IDLE) && (count_q < i_compare);
endmodule
`default_nettype wire

// ---- hw/dead_band_pair.sv ----
`timescale 1ns/10ps
`default_nettype none
module dead_band_pair
    import tcu_pkg::*;
#(
    parameter int W = DEAD_W
)(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_raw,
    input wire logic [W-1:0] i_dead,
    input wire logic i_kill,
    output logic o_true,
    output logic o_compl
);
    logic prev_q, prev_d;
    logic [W-1:0] wait_q, wait_d;
    logic true_q, true_d;
    logic compl_q, compl_d;

    // both legs stay low for the dead time after each raw edge
    always_comb begin
        prev_d = i_raw;
        wait_d = wait_q;
        true_d = i_raw;
        compl_d = !i_raw;
        if (i_kill) begin
            true_d = 1'b0;
            compl_d = 1'b0;
            wait_d = i_dead;
        end else if (i_raw != prev_q && i_dead != '0) begin
            wait_d = i_dead - 1'b1;
            true_d = 1'b0;
            compl_d = 1'b0;
        end else if (wait_q != '0) begin
            wait_d = wait_q - 1'b1;
            true_d = 1'b0;
            compl_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            prev_q <= 1'b0;
            wait_q <= '0;
            true_q <= 1'b0;
            compl_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            wait_q <= wait_d;
            true_q <= true_d;
            compl_q <= compl_d;
        end
    end

    assign o_true = true_q;
    assign o_compl = compl_q;
endmodule
`default_nettype wire

// ---- bench/tcu_checker_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcu_checker
    import tcu_pkg::*;
#(
    parameter int N_CH = NUM_CH
)(
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [N_CH-1:0] I_KILL,
    input wire logic [DATA_W-1:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [N_CH-1:0] O_PWM,
    input wire logic [N_CH-1:0] O_PWM_N,
    input wire logic O_IRQ
);
    logic setup_q;
    logic [N_CH-1:0] kill_q;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    // remembers last setup cycle and kill level, read data may only move after a setup
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            setup_q <= 1'b0;
            kill_q <= '0;
        end else begin
            setup_q <= I_PSEL && !I_PENABLE;
            kill_q <= I_KILL;
        end
    end
    a_setup_ready: assert property (I_PSEL && !I_PENABLE |=> O_PREADY) else $error("no ready after setup");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready held two cycles");
    a_ready_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE) else $error("ready outside access");
    a_err_clean: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == '0) else $error("bad error reply");
    a_prdata_holds: assert property (!setup_q |-> $stable(O_PRDATA)) else $error("read data moved");
    a_no_overlap: assert property (!(|(O_PWM & O_PWM_N))) else $error("both outputs high");
    a_kill_safe: assert property (|I_KILL |=> ((O_PWM | O_PWM_N) & $past(I_KILL)) == '0)
        else $error("kill did not force outputs low");
    a_kill_release: assert property (|(kill_q & ~I_KILL) |=> ((O_PWM | O_PWM_N) & $past(kill_q)) == '0)
        else $error("outputs resumed without gap");
    c_kill: cover property (|(I_KILL & kill_q));
    c_error: cover property (O_PSLVERR);
    c_irq: cover property (O_IRQ);
endmodule
bind timer_counter_pwm_unit tcu_checker #(.N_CH(N_CH)) u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_KILL(I_KILL), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_PWM(O_PWM), .O_PWM_N(O_PWM_N), .O_IRQ(O_IRQ));
`default_nettype wire

// ---- bench/event_source_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module event_source_model
    import tcu_pkg::*;
(
    input wire logic i_clk,
    input wire logic [NUM_CH-1:0] i_pwm,
    input wire logic [NUM_CH-1:0] i_pwm_n,
    output logic [NUM_CH-1:0] o_capture,
    output logic [NUM_CH-1:0] o_kill
);
    int overlap_count;
    // event lines idle low until asked
    initial begin
        o_capture = '0;
        o_kill = '0;
        overlap_count = 0;
    end
    // a switch pair conducting together would short the supply
    always @(posedge i_clk) begin
        if (|(i_pwm & i_pwm_n)) overlap_count++;
    end
    // one clean rising edge per event
    task automatic capture_pulse(input int ch);
        @(posedge i_clk);
        o_capture[ch] <= 1'b1;
        @(posedge i_clk);
        o_capture[ch] <= 1'b0;
    endtask
    task automatic set_kill(input int ch, input logic lvl);
        @(posedge i_clk);
        o_kill[ch] <= lvl;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tcu_pkg::*;
    logic I_CLK_SYS, I_RESET, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, O_IRQ, err;
    logic [ADDR_W-1:0] I_PADDR;
    logic [DATA_W-1:0] I_PWDATA, O_PRDATA, rd;
    logic [NUM_CH-1:0] I_CAPTURE, I_KILL, O_PWM, O_PWM_N;
    int bad_count, samples_checked, hi_t, hi_c;
    timer_counter_pwm_unit u_dut (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
        .I_CAPTURE(I_CAPTURE), .I_KILL(I_KILL), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
        .O_PSLVERR(O_PSLVERR), .O_PWM(O_PWM), .O_PWM_N(O_PWM_N), .O_IRQ(O_IRQ));
    event_source_model u_src (.i_clk(I_CLK_SYS), .i_pwm(O_PWM), .i_pwm_n(O_PWM_N),
        .o_capture(I_CAPTURE), .o_kill(I_KILL));
    // 20 MHz system clock
    initial begin
        I_CLK_SYS = 1'b0;
        forever #25 I_CLK_SYS = ~I_CLK_SYS;
    end
    task automatic close_out;
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge I_CLK_SYS);
    endtask
    function automatic logic [ADDR_W-1:0] ra(input int ch, input int r);
        return ADDR_W'(ch * 32 + r * 4);
    endfunction
    // one apb transfer, entered just after a rising edge; no fixed answer time assumed
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        // one idle edge first: a release and the next request never share a time step
        @(posedge I_CLK_SYS);
        I_PSEL <= 1'b1;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK_SYS);
        I_PENABLE <= 1'b1;
        // only the watchdog ends a wait for ready
        do begin
            @(posedge I_CLK_SYS);
        end while (O_PREADY !== 1'b1);
        rd = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic e);
        apb(1'b0, a, '0);
        check(rd, exp);
        check({31'h0, err}, {31'h0, e});
    endtask
    // hang guard, far beyond the fewer than a thousand cycles the tests need
    initial begin
        #2000000;
        bad_count++;
        $display("wrong value at %0t: run timed out", $time);
        close_out;
    end
    initial begin
        I_RESET = 1'b1;
        I_PSEL = 1'b0;
        I_PENABLE = 1'b0;
        I_PWRITE = 1'b0;
        I_PADDR = '0;
        I_PWDATA = '0;
        tick(10);
        I_RESET <= 1'b0;
        tick(1);
        // reset values and an unmapped place
        rd_chk(ra(0, REG_CTRL), 32'h0, 1'b0);
        rd_chk(ra(0, REG_PERIOD), 32'h0000FFFF, 1'b0);
        rd_chk(ra(0, REG_COMPARE), 32'h0, 1'b0);
        rd_chk(ra(0, REG_DEAD), 32'h0, 1'b0);
        rd_chk(ADDR_INT_MASK, 32'h0, 1'b0);
        rd_chk(12'h200, 32'h0, 1'b1);
        // each channel keeps its own period, upper half dropped
        for (int ch = 0; ch < NUM_CH; ch++) wr(ra(ch, REG_PERIOD), 32'hABC00010 + ch);
        for (int ch = 0; ch < NUM_CH; ch++) rd_chk(ra(ch, REG_PERIOD), 32'h10 + ch, 1'b0);
        // one-shot halts at the period, unmasked match raises the interrupt
        wr(ADDR_INT_MASK, 32'h0808);
        wr(ra(3, REG_CTRL), 32'h3);
        tick(40);
        check({31'h0, O_IRQ}, 32'h1);
        rd_chk(ra(3, REG_COUNT), 32'h13, 1'b0);
        rd_chk(ra(3, REG_COUNT), 32'h13, 1'b0);
        u_src.capture_pulse(3);
        tick(3);
        rd_chk(ra(3, REG_CAPTURE), 32'h13, 1'b0);
        apb(1'b0, ADDR_INT_STATUS, '0);
        check(rd & 32'h0808, 32'h0808);
        apb(1'b0, ADDR_INT_STATUS, '0);
        check(rd & 32'h0800, 32'h0);
        wr(ADDR_INT_MASK, 32'h0);
        tick(2);
        check({31'h0, O_IRQ}, 32'h0);
        // clearing enable returns the count, continuous mode keeps matching
        wr(ra(3, REG_CTRL), 32'h0);
        tick(2);
        rd_chk(ra(3, REG_COUNT), 32'h0, 1'b0);
        wr(ra(4, REG_CTRL), 32'h1);
        tick(30);
        apb(1'b0, ADDR_INT_STATUS, '0);
        tick(30);
        apb(1'b0, ADDR_INT_STATUS, '0);
        check(rd & 32'h0010, 32'h0010);
        // prescaler slows the ticks to one in four clocks
        wr(ra(4, REG_CTRL), 32'h0);
        wr(ADDR_PRESCALE, 32'h3);
        rd_chk(ADDR_PRESCALE, 32'h3, 1'b0);
        wr(ra(5, REG_CTRL), 32'h3);
        tick(40);
        apb(1'b0, ADDR_INT_STATUS, '0);
        check(rd & 32'h0020, 32'h0);
        tick(100);
        apb(1'b0, ADDR_INT_STATUS, '0);
        check(rd & 32'h0020, 32'h0020);
        // 17-clock period, raw high 8, dead band 2 eats from both sides
        wr(ADDR_PRESCALE, 32'h0);
        wr(ra(0, REG_COMPARE), 32'h8);
        wr(ra(0, REG_DEAD), 32'h2);
        wr(ra(0, REG_CTRL), 32'h1);
        tick(40);
        hi_t = 0;
        hi_c = 0;
        repeat (170) begin
            @(posedge I_CLK_SYS);
            hi_t += O_PWM[0];
            hi_c += O_PWM_N[0];
        end
        check(32'(hi_t), 32'h3C);
        check(32'(hi_c), 32'h46);
        check({25'h0, O_PWM[7:1]}, 32'h0);
        u_src.set_kill(0, 1'b1);
        tick(2);
        check({30'h0, O_PWM[0], O_PWM_N[0]}, 32'h0);
        u_src.set_kill(0, 1'b0);
        tick(40);
        check(32'(u_src.overlap_count), 32'h0);
        close_out;
    end
endmodule
`default_nettype wire
